/* core/wwdt_pkg.sv */
package wwdt_pkg;
    // Oscillator and prescaler timing
    localparam int          OSC_FREQ_KHZ    = 32;            // Nominal oscillator rate
    localparam int          PRE_PERIOD_US_S = 1000;          // Prescaler period, divide-by-32
    localparam int          PRE_PERIOD_US_L = 4000;          // Prescaler period, divide-by-128
    localparam int          CLK_PERIOD_NS   = 8;             // System clock period
    localparam int          PRE_PERIOD_CYC_S = PRE_PERIOD_US_S * 1000 / CLK_PERIOD_NS; // Cycles, short mode
    // Prescaler widths in bits
    localparam logic [4:0]  PRE_BITS_SHORT  = 5'h05;         // Divide by 32
    localparam logic [4:0]  PRE_BITS_LONG   = 5'h07;         // Divide by 128
    // Combined prescaler and postscaler count width
    localparam int          CNT_W           = 22;
    // Reset values
    localparam logic        SW_EN_RST       = 1'h0;          // Software enable after reset
    localparam logic        FLAG_RST        = 1'h0;          // Time-out flag after power-on
    // Status bit positions in the reset control register
    localparam int          BIT_SW_ENABLE   = 5;
    localparam int          BIT_TIMEOUT     = 4;
    localparam int          BIT_SLEEP       = 3;
    localparam int          BIT_IDLE        = 2;

    // Configuration word fields
    typedef struct packed {
        logic       hw_wdog_enable;    // Watchdog always on
        logic       window_disable;    // 1 selects non-window mode
        logic       prescale_select;   // 1 selects divide by 128
        logic [3:0] postscale_select;  // Ratio is two to this power
    } wwdt_config_s;

    // Power state
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_SAVE  = 2'b10
    } wwdt_state_e;
endpackage : wwdt_pkg

/* core/wwdt_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - Counts oscillator ticks; enable also starts oscillator
// - Prescaler divides by 32 or 128
// - Prescaler period about 1 ms or 4 ms
// - Four-bit postscaler picks ratio 1 to 32768
// - Resets, switches, power-save and clears zero counters
// - Counts in sleep; time-out wakes device
// - Hardware enable forces watchdog and oscillator on
// - Otherwise software enable bit gates watchdog
// - Every device reset clears software enable
// - Window disable bit selects non-window mode
// - Early clear while awake in window mode causes reset
// - Time-out sets sticky flag until software clears
module wwdt_top
    import wwdt_pkg::*;
(
    input  wire logic                   CLK,               // System clock, 125 MHz
    input  wire logic                   RST_B,             // Power-on reset, async, active low
    input  wire wwdt_pkg::wwdt_config_s CONFIG,            // Configuration word fields
    input  wire logic                   OSC_TICK,          // One pulse per oscillator period
    input  wire logic                   DEV_RESET,         // Any device reset, one-cycle pulse
    input  wire logic                   CLK_SWITCH_DONE,   // Clock switch completed, pulse
    input  wire logic                   POWER_SAVE_INSTR,  // Sleep or idle entered, pulse
    input  wire logic                   WAKE_EVENT,        // Other wake source, pulse
    input  wire logic                   CLEAR_INSTR,       // Watchdog clear instruction, pulse
    input  wire logic                   SW_ENABLE_WR,      // Write strobe for software enable
    input  wire logic                   SW_ENABLE_DATA,    // Value written to software enable
    input  wire logic                   TIMEOUT_FLAG_CLR,  // Software clear of time-out flag
    output logic                        OSC_ENABLE,        // Oscillator run request
    output logic                        SW_ENABLE,         // Software enable bit readback
    output logic                        TIMEOUT_FLAG,      // Sticky time-out flag
    output logic                        RESET_REQ,         // Watchdog reset request, pulse
    output logic                        WAKE_REQ,          // Wake from power save, pulse
    output logic                        IN_POWER_SAVE      // Core is in sleep or idle
);
    import wwdt_pkg::*;

    logic [CNT_W-1:0] cnt;            // Prescaler and postscaler chain
    logic [CNT_W-1:0] next_cnt;       // Next count
    wwdt_state_e      state;          // Power state
    wwdt_state_e      next_state;     // Next power state
    logic             sw_en;          // Software enable bit
    logic             next_sw_en;     // Next software enable
    logic             flag;           // Time-out flag
    logic             next_flag;      // Next flag
    logic             rst_req;        // Registered reset request
    logic             next_rst_req;   // Next reset request
    logic             wake;           // Registered wake request
    logic             next_wake;      // Next wake request
    logic             osc_en;         // Registered oscillator enable
    logic             enabled;        // Watchdog running
    logic [4:0]       period_bits;    // Log2 of the full period in ticks
    logic [CNT_W:0]   total;          // Ticks per time-out period
    logic [CNT_W-1:0] last;           // Final count before time-out
    logic [CNT_W-1:0] win_start;      // First count of the last quarter
    logic             timeout;        // Time-out this cycle
    logic             early;          // Clear issued outside the window
    logic             wake_exit;      // Leaving power save this cycle
    logic             clr_evt;        // Counter clear this cycle

    // Enable and period decode
    always_comb begin
        enabled     = CONFIG.hw_wdog_enable | sw_en;
        // Prescaler width, then postscaler ratio on top
        period_bits = (CONFIG.prescale_select ? PRE_BITS_LONG : PRE_BITS_SHORT)
                      + {1'b0, CONFIG.postscale_select};
        total       = {{CNT_W{1'b0}}, 1'b1} << period_bits;
        last        = CNT_W'(total - 1'b1);
        win_start   = CNT_W'(total - (total >> 2));
    end

    // Event decode
    always_comb begin
        timeout   = enabled & OSC_TICK & (cnt == last);
        early     = enabled & CLEAR_INSTR & (state == ST_RUN)
                    & ~CONFIG.window_disable & (cnt < win_start);
        wake_exit = (state == ST_SAVE) & (WAKE_EVENT | timeout);
        // Any of these zeroes the whole chain; a stopped watchdog stays zero
        clr_evt   = DEV_RESET | CLK_SWITCH_DONE | POWER_SAVE_INSTR
                    | wake_exit | CLEAR_INSTR | ~enabled;
    end

    // Counter next value
    always_comb begin
        if (clr_evt) begin
            next_cnt = '0;
        end else if (timeout) begin
            next_cnt = '0;                                                     // Restart after time-out
        end else if (OSC_TICK) begin
            next_cnt = cnt + 1'b1;
        end else begin
            next_cnt = cnt;                                                    // Hold between ticks
        end
    end

    // Power state next value
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (POWER_SAVE_INSTR && !DEV_RESET) begin
                    next_state = ST_SAVE;                                      // Enter sleep or idle
                end
            end
            ST_SAVE: begin
                if (wake_exit || DEV_RESET) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;                                           // Recover illegal code
            end
        endcase
    end

    // Control and status next values
    always_comb begin
        // Software enable; device reset clears it
        if (DEV_RESET) begin
            next_sw_en = 1'b0;
        end else if (SW_ENABLE_WR) begin
            next_sw_en = SW_ENABLE_DATA;
        end else begin
            next_sw_en = sw_en;
        end
        // Sticky flag; a new event wins over a software clear
        if (timeout || early) begin
            next_flag = 1'b1;
        end else if (TIMEOUT_FLAG_CLR) begin
            next_flag = 1'b0;
        end else begin
            next_flag = flag;
        end
        next_rst_req = (timeout & (state == ST_RUN)) | early;
        next_wake    = timeout & (state == ST_SAVE);
    end

    // State registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt     <= '0;
            state   <= ST_RUN;
            sw_en   <= SW_EN_RST;
            flag    <= FLAG_RST;
            rst_req <= 1'b0;
            wake    <= 1'b0;
            osc_en  <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            state   <= next_state;
            sw_en   <= next_sw_en;
            flag    <= next_flag;
            rst_req <= next_rst_req;
            wake    <= next_wake;
            osc_en  <= enabled;
        end
    end

    // Outputs from flip-flops; IN_POWER_SAVE is decoded from the state register
    assign OSC_ENABLE    = osc_en;
    assign SW_ENABLE     = sw_en;
    assign TIMEOUT_FLAG  = flag;
    assign RESET_REQ     = rst_req;
    assign WAKE_REQ      = wake;
    assign IN_POWER_SAVE = (state == ST_SAVE);

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    osc_follows_enable_a: assert property (CONFIG.hw_wdog_enable |=> OSC_ENABLE)
        else $error("Oscillator off while hardware enable set");
    clear_zeroes_count_a: assert property (CLEAR_INSTR |=> cnt == '0)
        else $error("Clear instruction did not zero the counter");
    tick_advances_a: assert property (enabled && OSC_TICK && !clr_evt && cnt != last
                                      |=> cnt == $past(cnt) + 1'b1)
        else $error("Tick did not advance the counter");
    awake_timeout_reset_a: assert property (timeout && state == ST_RUN
                                            |=> RESET_REQ && TIMEOUT_FLAG)
        else $error("Awake time-out missed reset or flag");
    sleep_timeout_wake_a: assert property (timeout && state == ST_SAVE
                                           |=> WAKE_REQ && !RESET_REQ && !IN_POWER_SAVE)
        else $error("Sleep time-out did not wake");
    early_clear_reset_a: assert property (CLEAR_INSTR && enabled && !CONFIG.window_disable
                                          && state == ST_RUN && cnt < win_start |=> RESET_REQ)
        else $error("Early clear did not request reset");
    nowindow_no_reset_a: assert property (CONFIG.window_disable && !timeout |=> !RESET_REQ)
        else $error("Reset in non-window mode without time-out");
    reset_clears_sw_a: assert property (DEV_RESET |=> !SW_ENABLE)
        else $error("Device reset left software enable set");
    flag_sticky_a: assert property (TIMEOUT_FLAG && !TIMEOUT_FLAG_CLR |=> TIMEOUT_FLAG)
        else $error("Time-out flag dropped without clear");
    sw_gate_a: assert property (!CONFIG.hw_wdog_enable && !SW_ENABLE |-> !timeout)
        else $error("Time-out while disabled");
    period_short_a: assert property (CONFIG.prescale_select == 1'b0 && CONFIG.postscale_select == 4'h0
                                     |-> last == CNT_W'(31))
        else $error("Short prescaler period wrong");

    // Period decode at the other corners
    // Divide by 128 with ratio one ends at count 127
    period_long_a: assert property (CONFIG.prescale_select && CONFIG.postscale_select == 4'h0
                                    |-> last == 22'h7f)
        else $error("Long prescaler period wrong");
    // Largest ratio uses the whole chain
    period_max_a: assert property (CONFIG.prescale_select && CONFIG.postscale_select == 4'hf
                                   |-> last == 22'h3fffff)
        else $error("Largest postscaler ratio wrong");
    // Window opens at three quarters of the short period
    window_start_a: assert property (!CONFIG.prescale_select && CONFIG.postscale_select == 4'h0
                                     |-> win_start == 22'h18)
        else $error("Window start wrong");

    // Counter clear sources
    // Entering power save zeroes the chain
    save_entry_clears_a: assert property (POWER_SAVE_INSTR |=> cnt == '0)
        else $error("Power-save entry did not zero the counter");
    // A finished clock switch zeroes the chain
    switch_clears_a: assert property (CLK_SWITCH_DONE |=> cnt == '0)
        else $error("Clock switch did not zero the counter");
    // Device reset zeroes the chain and returns to run
    devrst_clears_a: assert property (DEV_RESET |=> cnt == '0 && !IN_POWER_SAVE)
        else $error("Device reset did not zero the counter");
    // Leaving power save zeroes the chain
    wake_clears_count_a: assert property (wake_exit |=> cnt == '0)
        else $error("Wake did not zero the counter");
    // A stopped watchdog holds zero
    disabled_holds_zero_a: assert property (!enabled |=> cnt == '0)
        else $error("Disabled watchdog counted");
    // Time-out restarts the count
    timeout_restart_a: assert property (timeout |=> cnt == '0)
        else $error("Counter not restarted after time-out");
    // Between ticks the count holds
    tick_idle_hold_a: assert property (!OSC_TICK && !clr_evt |=> cnt == $past(cnt))
        else $error("Counter moved without a tick");
    // Counting goes on in power save
    save_counts_a: assert property (state == ST_SAVE && OSC_TICK && !clr_evt && cnt != last
                                    |=> cnt == $past(cnt) + 1'b1)
        else $error("Counter stalled in power save");

    // Power state
    // Power-save entry from run
    save_entry_a: assert property (POWER_SAVE_INSTR && !DEV_RESET && state == ST_RUN
                                   |=> IN_POWER_SAVE)
        else $error("Power-save entry missed");
    // Another wake source leaves power save
    wake_event_exit_a: assert property (state == ST_SAVE && WAKE_EVENT |=> !IN_POWER_SAVE)
        else $error("Wake event did not leave power save");
    // State code is always legal
    state_legal_a: assert property (state == ST_RUN || state == ST_SAVE)
        else $error("Illegal power state");

    // Reset and wake requests
    // No reset request from power save
    save_no_reset_a: assert property (state == ST_SAVE |=> !RESET_REQ)
        else $error("Reset requested from power save");
    // No wake request while awake
    awake_no_wake_a: assert property (state == ST_RUN |=> !WAKE_REQ)
        else $error("Wake requested while awake");
    // Reset request only after time-out or early clear
    reset_only_events_a: assert property (!timeout && !early |=> !RESET_REQ)
        else $error("Reset request without cause");
    // Wake request only after time-out
    wake_only_timeout_a: assert property (!timeout |=> !WAKE_REQ)
        else $error("Wake request without time-out");
    // Wake request lasts one cycle
    wake_pulse_a: assert property (WAKE_REQ |=> !WAKE_REQ)
        else $error("Wake request longer than one cycle");
    // A clear inside the window is safe
    late_clear_safe_a: assert property (CLEAR_INSTR && state == ST_RUN && cnt >= win_start
                                        && !timeout |=> !RESET_REQ)
        else $error("Reset on a clear inside the window");
    // A clear in power save never resets
    save_clear_safe_a: assert property (CLEAR_INSTR && state == ST_SAVE |=> !RESET_REQ)
        else $error("Reset on a clear in power save");

    // Flag and enable bits
    // Time-out in power save sets the flag
    wake_sets_flag_a: assert property (timeout && state == ST_SAVE |=> TIMEOUT_FLAG)
        else $error("Sleep time-out left flag clear");
    // Early clear sets the flag and zeroes the count
    early_sets_flag_a: assert property (early |=> TIMEOUT_FLAG && cnt == '0)
        else $error("Early clear left flag clear");
    // A new event wins over a software clear
    flag_set_wins_a: assert property ((timeout || early) && TIMEOUT_FLAG_CLR |=> TIMEOUT_FLAG)
        else $error("Software clear beat a new event");
    // Software clear drops the flag when nothing new happens
    flag_clear_a: assert property (TIMEOUT_FLAG_CLR && !timeout && !early |=> !TIMEOUT_FLAG)
        else $error("Software clear ignored");
    // Software write lands in the enable bit
    sw_write_a: assert property (SW_ENABLE_WR && !DEV_RESET |=> SW_ENABLE == $past(SW_ENABLE_DATA))
        else $error("Software enable write lost");
    // Enable bit holds without a write
    sw_hold_a: assert property (!SW_ENABLE_WR && !DEV_RESET |=> SW_ENABLE == $past(SW_ENABLE))
        else $error("Software enable changed by itself");
    // Hardware enable overrides the software bit
    hw_ignores_sw_a: assert property (CONFIG.hw_wdog_enable |-> enabled)
        else $error("Hardware enable did not force the watchdog on");
    // Software enable starts the oscillator
    osc_on_sw_a: assert property (SW_ENABLE |=> OSC_ENABLE)
        else $error("Oscillator off while software enable set");
    // Fully disabled watchdog stops the oscillator
    osc_off_disabled_a: assert property (!CONFIG.hw_wdog_enable && !SW_ENABLE |=> !OSC_ENABLE)
        else $error("Oscillator on while disabled");

    timeout_awake_c: cover property (timeout && state == ST_RUN);
    timeout_sleep_c: cover property (timeout && state == ST_SAVE);
    early_clear_c:   cover property (early);
    late_clear_c:    cover property (CLEAR_INSTR && !CONFIG.window_disable && cnt >= win_start);
    flag_clear_c:    cover property (TIMEOUT_FLAG ##1 TIMEOUT_FLAG_CLR ##1 !TIMEOUT_FLAG);
endmodule : wwdt_top

/* tb/wwdt_top_bench.sv */
`timescale 1ns/100ps
module wwdt_top_bench;
    import wwdt_pkg::*;
    logic         clk;         // System clock
    logic         rst_b;       // Power-on reset, active low
    wwdt_config_s cfg;         // Configuration word levels
    logic [7:0]   ev;          // Pulses: flag clr, sw wr, dev rst, switch, save, wake, clear, tick
    logic         sw_data;     // Value for software enable writes
    logic         osc_en;      // Oscillator run request
    logic         sw_en;       // Software enable readback
    logic         flag;        // Sticky time-out flag
    logic         rst_req;     // Reset request pulse
    logic         wake_req;    // Wake request pulse
    logic         in_save;     // Power-save state
    int           fail_count;  // Mismatches
    int           num_checks;  // Comparisons made
    int           rst_cnt;     // Reset request pulses seen
    int           wake_cnt;    // Wake request pulses seen
    int           cycles;      // Cycle count for hang guard
    int           base;        // Reset count before a step
    wwdt_top i_dut (.CLK(clk), .RST_B(rst_b), .CONFIG(cfg), .OSC_TICK(ev[0]), .CLEAR_INSTR(ev[1]),
        .WAKE_EVENT(ev[2]), .POWER_SAVE_INSTR(ev[3]), .CLK_SWITCH_DONE(ev[4]), .DEV_RESET(ev[5]),
        .SW_ENABLE_WR(ev[6]), .SW_ENABLE_DATA(sw_data), .TIMEOUT_FLAG_CLR(ev[7]), .OSC_ENABLE(osc_en),
        .SW_ENABLE(sw_en), .TIMEOUT_FLAG(flag), .RESET_REQ(rst_req), .WAKE_REQ(wake_req),
        .IN_POWER_SAVE(in_save));
    // Free-running clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    // Count output pulses and guard against a hang
    always @(posedge clk) begin
        cycles++;
        if (rst_req === 1'b1) rst_cnt++;
        if (wake_req === 1'b1) wake_cnt++;
        if (cycles == 50000) begin
            fail_count++;
            complete_run();
        end
    end
    // Compare one value with its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Let one edge pass, settle just after it
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    // Raise a set of pulses for exactly one cycle
    task automatic pulse(input logic [7:0] v);
        step();
        ev = v;
        step();
        ev = 8'h00;
    endtask : pulse
    // Send n oscillator ticks
    task automatic tick(input int n);
        repeat (n) pulse(8'h01);
    endtask : tick
    // Run to one tick short of time-out, then across it
    task automatic expire(input int total);
        base = rst_cnt;
        tick(total - 1);
        step();
        check(rst_cnt, base);
        tick(1);
        step();
        check(rst_cnt, base + 1);
        check(flag, 1'h1);
    endtask : expire
    // Print counts and verdict, end the run
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        cfg = '0;
        cfg.window_disable = 1'b1;
        ev = 8'h00;
        sw_data = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        step();
        check(sw_en, SW_EN_RST);
        check(flag, FLAG_RST);
        // Disabled watchdog ignores ticks
        tick(40);
        step();
        check(rst_cnt, 0);
        check(osc_en, 1'h0);
        sw_data = 1'b1;
        pulse(8'h40);
        step();
        check(sw_en, 1'h1);
        check(osc_en, 1'h1);
        // Both prescaler modes, two postscaler codes
        for (int p = 0; p < 2; p++) begin
            for (int q = 0; q < 2; q++) begin
                cfg.prescale_select = p[0];
                cfg.postscale_select = q[3:0];
                pulse(8'h02);
                expire(1 << (5 + 2 * p + q));
            end
        end
        pulse(8'h80);
        step();
        check(flag, 1'h0);
        // Clear, clock switch and device reset each restart the count; device reset goes first
        cfg = '0;
        cfg.window_disable = 1'b1;
        cfg.hw_wdog_enable = 1'b1;
        foreach (ev[i]) if (i == 1 || i == 4 || i == 5) begin
            tick(20);
            pulse(8'h01 << i);
            expire(32);
        end
        check(sw_en, 1'h0);
        check(osc_en, 1'h1);
        // Time-out during power save wakes instead of resetting
        pulse(8'h08);
        step();
        check(in_save, 1'h1);
        base = rst_cnt;
        tick(32);
        step();
        check(wake_cnt, 1);
        check(rst_cnt, base);
        check(in_save, 1'h0);
        pulse(8'h08);
        pulse(8'h04);
        step();
        check(in_save, 1'h0);
        // Window mode: clear at count 23 is early, at 24 is allowed
        cfg.window_disable = 1'b0;
        base = rst_cnt;
        pulse(8'h02);
        step();
        check(rst_cnt, base + 1);
        tick(23);
        pulse(8'h02);
        step();
        check(rst_cnt, base + 2);
        tick(24);
        pulse(8'h02);
        step();
        check(rst_cnt, base + 2);
        complete_run();
    end
endmodule : wwdt_top_bench
